// ### mars_restart_seq.v
// Purpose: decide whether and when a tripped motor restarts
// Assumes: operator and drive pins are asynchronous
// Notes: override settings arrive from same-clock logic
`timescale 1ns/1ps
`include "mars_consts.vh"

module mars_restart_seq #(
	parameter integer TICK_CYCLES = `MARS_CLK_HZ * `MARS_TICK_S
) (
	// clock and reset
	input wire sys_clk_i,
	input wire resetn_i,
	// register port
	input wire [7:0] addr_i,
	input wire [31:0] wr_data_i,
	input wire wr_i,
	input wire rd_i,
	output reg [31:0] rd_data_o,
	// operator and drive pins
	input wire stop_key_i,
	input wire start_key_i,
	input wire alarm_i,
	input wire telem_stop_i,
	input wire hoa_off_i,
	input wire hoa_auto_i,
	input wire hoa_hand_i,
	input wire trip_i,
	input wire power_fail_i,
	input wire overload_i,
	// per cause overrides for the pending cause
	input wire ovr_en_i,
	input wire [9:0] ovr_delay_i,
	input wire [7:0] ovr_max_i,
	// drive outputs
	output reg run_cmd_o,
	output reg lockout_o,
	output reg pending_o,
	output reg [11:0] remain_min_o,
	output reg [5:0] remain_sec_o
);

	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_WAIT = 4'b0010;
	localparam [3:0] ST_RUN = 4'b0100;
	localparam [3:0] ST_LOCK = 4'b1000;

	reg [`MARS_NPINS-1:0] meta_q;
	reg [`MARS_NPINS-1:0] pin_q;
	reg [`MARS_NPINS-1:0] prev_q;
	reg [3:0] ctrl_q;
	reg [7:0] max_q;
	reg [9:0] clr_q;
	reg [9:0] step_q;
	reg [9:0] dly_q;
	reg [9:0] stag_q;
	reg [3:0] state_q;
	reg [3:0] state_d;
	reg [7:0] att_q;
	reg [15:0] tot_q;
	reg [11:0] acc_q;
	reg [17:0] run_s_q;
	reg stop_blk_q;
	reg seen_off_q;
	reg fact_q;
	reg [31:0] rd_d;
	wire tick;
	wire stop_pe;
	wire start_pe;
	wire trip_pe;
	wire auto_ok;
	wire inhibit;
	wire start_ok;
	wire rem_zero;
	wire [7:0] lim;
	wire [11:0] dly_min;
	wire [17:0] clr_s;
	wire hoa_en;

	// ****************************************************************
	// timebase
	// ****************************************************************
	mars_sec_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.tick_o(tick)
	);

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	// two flops, then a third stage only for edge detection
	always @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_q <= {`MARS_NPINS{1'b0}};
			pin_q <= {`MARS_NPINS{1'b0}};
			prev_q <= {`MARS_NPINS{1'b0}};
		end else begin
			meta_q <= {overload_i, power_fail_i, trip_i, hoa_hand_i,
				hoa_auto_i, hoa_off_i, telem_stop_i, alarm_i,
				start_key_i, stop_key_i};
			pin_q <= meta_q;
			prev_q <= pin_q;
		end
	end

	assign stop_pe = pin_q[`MARS_P_STOP] & ~prev_q[`MARS_P_STOP];
	assign start_pe = pin_q[`MARS_P_START] & ~prev_q[`MARS_P_START];
	assign trip_pe = pin_q[`MARS_P_TRIP] & ~prev_q[`MARS_P_TRIP];
	assign hoa_en = ctrl_q[`MARS_B_HOAEN];

	// ****************************************************************
	// restart decisions
	// ****************************************************************
	// switch wins
	assign auto_ok = hoa_en ? pin_q[`MARS_P_AUTO] : ctrl_q[`MARS_B_AUTO];

	assign inhibit = pin_q[`MARS_P_ALARM] | stop_blk_q |
		pin_q[`MARS_P_TELEM] | ~auto_ok;

	assign lim = ovr_en_i ? ovr_max_i :
		(pin_q[`MARS_P_OVLD] & ctrl_q[`MARS_B_OVLD]) ? 8'h01 : max_q;

	assign dly_min = {2'b00, (ovr_en_i ? ovr_delay_i : dly_q)} + acc_q +
		(pin_q[`MARS_P_PWR] ? {2'b00, stag_q} : 12'h000);

	assign clr_s = {8'h00, clr_q} * `MARS_SEC_PER_MIN;

	assign start_ok = start_pe & ~pin_q[`MARS_P_ALARM] &
		~pin_q[`MARS_P_TELEM] & ~(hoa_en & pin_q[`MARS_P_OFF]) &
		~(state_q[1] & ctrl_q[`MARS_B_HOLD]);

	assign rem_zero = (remain_min_o == 12'h000) &
		(remain_sec_o == 6'h00);

	// ****************************************************************
	// next state
	// ****************************************************************
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (start_ok) begin
					state_d = ST_RUN;
				end
			end
			ST_WAIT: begin
				if (stop_pe | inhibit) begin
					state_d = ST_IDLE;
				end else if (start_ok) begin
					state_d = ST_RUN;
				end else if (tick & rem_zero) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (stop_pe | pin_q[`MARS_P_TELEM]) begin
					state_d = ST_IDLE;
				end else if (hoa_en & pin_q[`MARS_P_OFF]) begin
					state_d = ST_IDLE;
				end else if (trip_pe) begin
					if (att_q >= lim) begin
						state_d = ST_LOCK;
					end else if (!inhibit) begin
						state_d = ST_WAIT;
					end else begin
						state_d = ST_IDLE;
					end
				end
			end
			ST_LOCK: begin
				if (stop_pe) begin
					state_d = ST_IDLE;
				end else if (seen_off_q & (pin_q[`MARS_P_AUTO] |
					pin_q[`MARS_P_HAND])) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// ****************************************************************
	// sequencer registers
	// ****************************************************************
	always @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= ST_IDLE;
			att_q <= 8'h00;
			tot_q <= 16'h0000;
			acc_q <= 12'h000;
			run_s_q <= 18'h0_0000;
			stop_blk_q <= 1'b0;
			seen_off_q <= 1'b0;
			remain_min_o <= 12'h000;
			remain_sec_o <= 6'h00;
			run_cmd_o <= 1'b0;
			lockout_o <= 1'b0;
			pending_o <= 1'b0;
		end else begin
			state_q <= state_d;
			run_cmd_o <= state_d[2];
			lockout_o <= state_d[3];
			pending_o <= state_d[1];
			// stop key blocks restarts until a manual start
			if (stop_pe) begin
				stop_blk_q <= 1'b1;
			end else if (state_d[2] & ~state_q[2]) begin
				stop_blk_q <= 1'b0;
			end
			// only an off seen during this lockout lets the switch clear it
			if (!state_q[3]) begin
				seen_off_q <= 1'b0;
			end else if (hoa_en & pin_q[`MARS_P_OFF]) begin
				seen_off_q <= 1'b1;
			end
			if (fact_q) begin
				tot_q <= 16'h0000;
			end else if (state_d[2] & ~state_q[2]) begin
				tot_q <= tot_q + 16'h0001;
			end
			if (state_q[2] & state_d[1]) begin
				remain_min_o <= dly_min;
				remain_sec_o <= 6'h00;
			end else if (!state_d[1]) begin
				remain_min_o <= 12'h000;
				remain_sec_o <= 6'h00;
			end else if (tick & ~rem_zero) begin
				if (remain_sec_o == 6'h00) begin
					remain_min_o <= remain_min_o - 12'h001;
					remain_sec_o <= `MARS_SEC_LAST;
				end else begin
					remain_sec_o <= remain_sec_o - 6'h01;
				end
			end
			// run time resets each start, saturates at the clear mark
			if (!state_q[2]) begin
				run_s_q <= 18'h0_0000;
			end else if (tick & (run_s_q < clr_s)) begin
				run_s_q <= run_s_q + 18'h0_0001;
			end
			if (state_q[1] & state_d[2] & tick & rem_zero) begin
				att_q <= att_q + 8'h01;
				acc_q <= acc_q + {2'b00, step_q};
			end else if (state_q[3] & ~state_d[3]) begin
				att_q <= 8'h00;
				acc_q <= 12'h000;
			end else if (state_q[2] & (run_s_q >= clr_s)) begin
				att_q <= 8'h00;
				acc_q <= 12'h000;
			end
		end
	end

	// ****************************************************************
	// register writes
	// ****************************************************************
	// factory defaults reload every setting and the total count
	always @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_q <= `MARS_R_CTRL;
			max_q <= `MARS_R_MAX;
			clr_q <= `MARS_R_CLR;
			step_q <= `MARS_R_STEP;
			dly_q <= `MARS_R_DLY;
			stag_q <= `MARS_R_STAG;
			fact_q <= 1'b0;
		end else begin
			fact_q <= wr_i & (addr_i == `MARS_A_CTRL) &
				wr_data_i[`MARS_B_FACT];
			if (fact_q) begin
				ctrl_q <= `MARS_R_CTRL;
				max_q <= `MARS_R_MAX;
				clr_q <= `MARS_R_CLR;
				step_q <= `MARS_R_STEP;
				dly_q <= `MARS_R_DLY;
				stag_q <= `MARS_R_STAG;
			end else if (wr_i) begin
				case (addr_i)
					`MARS_A_CTRL: begin
						ctrl_q <= wr_data_i[3:0];
					end
					`MARS_A_MAX: begin
						max_q <= wr_data_i[7:0];
					end
					`MARS_A_CLR: begin
						clr_q <= wr_data_i[9:0];
					end
					`MARS_A_STEP: begin
						step_q <= wr_data_i[9:0];
					end
					`MARS_A_DLY: begin
						dly_q <= wr_data_i[9:0];
					end
					`MARS_A_STAG: begin
						stag_q <= wr_data_i[9:0];
					end
					default: begin
						ctrl_q <= ctrl_q;
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// register reads
	// ****************************************************************
	// unmapped offsets read as zero
	always @* begin
		rd_d = 32'h0000_0000;
		case (addr_i)
			`MARS_A_CTRL: rd_d = {28'h000_0000, ctrl_q};
			`MARS_A_MAX: rd_d = {24'h00_0000, max_q};
			`MARS_A_CLR: rd_d = {22'h00_0000, clr_q};
			`MARS_A_STEP: rd_d = {22'h00_0000, step_q};
			`MARS_A_DLY: rd_d = {22'h00_0000, dly_q};
			`MARS_A_STAG: rd_d = {22'h00_0000, stag_q};
			`MARS_A_STAT: rd_d = {24'h00_0000, stop_blk_q,
				pin_q[`MARS_P_ALARM], 2'b00, state_q};
			`MARS_A_ATT: rd_d = {24'h00_0000, att_q};
			`MARS_A_TOT: rd_d = {16'h0000, tot_q};
			`MARS_A_REM: rd_d = {12'h000, remain_min_o, 2'b00,
				remain_sec_o};
			default: rd_d = 32'h0000_0000;
		endcase
	end

	// data stand only in the cycle after the strobe
	always @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rd_data_o <= 32'h0000_0000;
		end else begin
			rd_data_o <= rd_i ? rd_d : 32'h0000_0000;
		end
	end

endmodule // mars_restart_seq

// ### mars_consts.vh
// Purpose: constants for the motor auto restart sequencer
// Assumes: 50 MHz system clock, 32-bit plain register port
// Notes: offsets are byte addresses, one aligned word each
// Operation
// - auto restart enable allows automatic restarts
// - enabled hand-off-auto switch overrides enable
// - attempt counter counts automatic restarts, readable
// - stop key or switch off-on clears lockout
// - total starts cleared only by factory defaults
// - attempt limit reached enters lockout
// - attempt limit unless per-cause override enabled
// - run for clear delay zeroes attempt counter
// - progressive step added from second attempt
// - progressive addition cleared after clear delay run
// - wait restart delay before automatic restart
// - manual start skips the restart delay
// - no restart while any alarm active
// - per-cause override supplies delay and attempts
// - remaining wait shown as minutes and seconds
// - remaining zero while restarts are inhibited
// - power failure adds staggered offset delay
// - hold setting refuses manual starts during delay
// - overload setting allows exactly one restart
`ifndef MARS_CONSTS_VH
`define MARS_CONSTS_VH

// ****************************************************************
// timing
// ****************************************************************
`define MARS_CLK_HZ 50000000
`define MARS_TICK_S 1
`define MARS_SEC_PER_MIN 18'h0_003C
`define MARS_SEC_LAST 6'h3B

// ****************************************************************
// register offsets
// ****************************************************************
`define MARS_A_CTRL 8'h00
`define MARS_A_MAX 8'h04
`define MARS_A_CLR 8'h08
`define MARS_A_STEP 8'h0C
`define MARS_A_DLY 8'h10
`define MARS_A_STAG 8'h14
`define MARS_A_STAT 8'h18
`define MARS_A_ATT 8'h1C
`define MARS_A_TOT 8'h20
`define MARS_A_REM 8'h24

// ****************************************************************
// control fields and reset values
// ****************************************************************
`define MARS_B_AUTO 0
`define MARS_B_HOAEN 1
`define MARS_B_HOLD 2
`define MARS_B_OVLD 3
`define MARS_B_FACT 8
`define MARS_R_CTRL 4'h1
`define MARS_R_MAX 8'h03
`define MARS_R_CLR 10'h03C
`define MARS_R_STEP 10'h000
`define MARS_R_DLY 10'h01E
`define MARS_R_STAG 10'h000

// ****************************************************************
// pin vector positions
// ****************************************************************
`define MARS_P_STOP 0
`define MARS_P_START 1
`define MARS_P_ALARM 2
`define MARS_P_TELEM 3
`define MARS_P_OFF 4
`define MARS_P_AUTO 5
`define MARS_P_HAND 6
`define MARS_P_TRIP 7
`define MARS_P_PWR 8
`define MARS_P_OVLD 9
`define MARS_NPINS 10

`endif

// ### mars_sec_tick.v
// Purpose: one second tick from the system clock
// Assumes: count shortened by parameter in simulation
// Notes: tick is a single cycle pulse
`timescale 1ns/1ps
`include "mars_consts.vh"

module mars_sec_tick #(
	parameter integer TICK_CYCLES = `MARS_CLK_HZ * `MARS_TICK_S
) (
	// clock and reset
	input wire sys_clk_i,
	input wire resetn_i,
	// tick
	output reg tick_o
);

	reg [31:0] cnt_q;

	// ****************************************************************
	// divider
	// ****************************************************************
	// second tick
	always @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_q <= 32'h0000_0000;
			tick_o <= 1'b0;
		end else if (cnt_q >= TICK_CYCLES - 1) begin
			cnt_q <= 32'h0000_0000;
			tick_o <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h0000_0001;
			tick_o <= 1'b0;
		end
	end

endmodule // mars_sec_tick

// ### mars_restart_seq_assertions.sv
// Purpose: port checks for the restart sequencer
// Assumes: one clock, reset active low and asynchronous
// Notes: pin effects lag three to four clocks, so windows are six
`timescale 1ns/1ps

module mars_restart_seq_assertions (
	input wire sys_clk_i, resetn_i, rd_i, start_key_i, stop_key_i,
	input wire alarm_i, telem_stop_i, run_cmd_o, lockout_o, pending_o,
	input wire [31:0] rd_data_o,
	input wire [11:0] remain_min_o,
	input wire [5:0] remain_sec_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	// ****
	// countdown steps
	// ****
	// no manual start in flight, so a start can only be the expiry
	sequence s_no_start;
		!start_key_i [*6];
	endsequence
	sequence s_expire;
		$fell(pending_o) && run_cmd_o;
	endsequence
	sequence s_step;
		pending_o && $past(pending_o) && $changed(remain_sec_o);
	endsequence
	property p_expiry;
		s_no_start ##0 s_expire |->
			$past(remain_min_o) == 12'h000 && $past(remain_sec_o) == 6'h00;
	endproperty
	property p_wrap;
		s_step ##0 remain_sec_o == 6'h3B |-> $past(remain_sec_o) == 6'h00
			&& remain_min_o == $past(remain_min_o) - 12'h001;
	endproperty
	property p_dec;
		s_step ##0 remain_sec_o != 6'h3B |->
			remain_sec_o == $past(remain_sec_o) - 6'h01;
	endproperty
	// a fast tick is the hazard: steps closer than the tick are wrong
	property p_tick;
		s_step |=> ($stable(remain_sec_o) || !pending_o) [*8];
	endproperty
	// ****
	// inhibits and port
	// ****
	property p_alarm;
		alarm_i [*6] |-> !pending_o && !$rose(run_cmd_o);
	endproperty
	property p_telem;
		telem_stop_i [*6] |-> !pending_o && remain_min_o == 12'h000;
	endproperty
	property p_stop;
		(stop_key_i && !start_key_i) [*6] |-> !run_cmd_o && !pending_o;
	endproperty
	property p_lock;
		lockout_o |-> !run_cmd_o && !pending_o;
	endproperty
	property p_rd;
		!$past(rd_i) |-> rd_data_o == 32'h0000_0000;
	endproperty
	a_expiry: assert property (p_expiry)
		else $error("restart before wait ended");
	a_wrap: assert property (p_wrap)
		else $error("bad minute borrow");
	a_dec: assert property (p_dec)
		else $error("bad second step");
	a_tick: assert property (p_tick)
		else $error("countdown faster than tick");
	a_alarm: assert property (p_alarm)
		else $error("restart pending under alarm");
	a_telem: assert property (p_telem)
		else $error("wait shown under telemetry stop");
	a_stop: assert property (p_stop)
		else $error("running with stop held");
	a_lock: assert property (p_lock)
		else $error("start during lockout");
	a_rd: assert property (p_rd)
		else $error("read data outside its cycle");
endmodule // mars_restart_seq_assertions

bind mars_restart_seq mars_restart_seq_assertions i_chk (.sys_clk_i,
	.resetn_i, .rd_i, .start_key_i, .stop_key_i, .alarm_i, .telem_stop_i,
	.run_cmd_o, .lockout_o, .pending_o, .rd_data_o, .remain_min_o,
	.remain_sec_o);

// ### mars_drive_model.sv
// Purpose: drive power stage seen from the sequencer
// Assumes: fault request comes from the bench
// Notes: trip line only rises on a running drive
`timescale 1ns/1ps

module mars_drive_model (
	// clock and reset
	input wire sys_clk_i,
	input wire resetn_i,
	// sequencer and bench side
	input wire run_cmd_i,
	input wire fault_i,
	output reg trip_o
);
	// an idle drive cannot trip; a trip holds while the fault lasts
	always @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			trip_o <= 1'b0;
		else
			trip_o <= fault_i & (run_cmd_i | trip_o);
	end
endmodule // mars_drive_model

// ### tb_motor_auto_restart_sequencer.sv
// Purpose: directed test of the restart sequencer
// Assumes: tick shortened to ten clocks, a minute is 600 clocks
// Notes: keys are held eight clocks to pass the synchronisers
`timescale 1ns/1ps
`include "mars_consts.vh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
	$display("[ERR] %0t got %h exp %h", $time, a, e); end end

module tb_motor_auto_restart_sequencer;
	reg sys_clk_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
	reg [7:0] addr_i = 8'h00, ovr_max_i = 8'h03;
	reg [31:0] wr_data_i = 32'h0000_0000;
	reg stop_key_i = 1'b0, start_key_i = 1'b0, alarm_i = 1'b0;
	reg telem_stop_i = 1'b0, hoa_off_i = 1'b0, hoa_auto_i = 1'b1;
	reg hoa_hand_i = 1'b0, power_fail_i = 1'b0, overload_i = 1'b0;
	reg ovr_en_i = 1'b0, fault = 1'b0;
	reg [9:0] ovr_delay_i = 10'h003;
	wire trip_i, run_cmd_o, lockout_o, pending_o;
	wire [31:0] rd_data_o;
	wire [11:0] remain_min_o;
	wire [5:0] remain_sec_o;
	integer error_cnt = 0, tests_run = 0;

	mars_restart_seq #(.TICK_CYCLES(10)) i_dut (.sys_clk_i, .resetn_i,
		.addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .stop_key_i,
		.start_key_i, .alarm_i, .telem_stop_i, .hoa_off_i, .hoa_auto_i,
		.hoa_hand_i, .trip_i, .power_fail_i, .overload_i, .ovr_en_i,
		.ovr_delay_i, .ovr_max_i, .run_cmd_o, .lockout_o, .pending_o,
		.remain_min_o, .remain_sec_o);
	mars_drive_model i_drv (.sys_clk_i, .resetn_i, .run_cmd_i(run_cmd_o),
		.fault_i(fault), .trip_o(trip_i));

	initial begin
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	// ****
	// bus and pin tasks
	// ****
	task wr(input [7:0] a, input [31:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask
	task rd(input [7:0] a, input [31:0] e);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1;
		`CHK(rd_data_o, e)
	endtask
	task key(input s);
		@(posedge sys_clk_i);
		if (s) stop_key_i <= 1'b1; else start_key_i <= 1'b1;
		repeat (8) @(posedge sys_clk_i);
		stop_key_i <= 1'b0;
		start_key_i <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		#1;
	endtask
	// k: 0 wait expected, 1 lockout expected, 2 neither
	task trip(input [11:0] m, input [1:0] k);
		integer i;
		@(posedge sys_clk_i);
		fault <= 1'b1;
		for (i = 0; i < 12; i++) begin
			@(posedge sys_clk_i);
			#1;
			if ((pending_o | lockout_o) === 1'b1) i = 12;
		end
		`CHK(pending_o, k == 2'd0)
		`CHK(lockout_o, k == 2'd1)
		if (k == 2'd0) `CHK(remain_min_o, m)
		if (k == 2'd0) `CHK(remain_sec_o, 6'h00)
		@(posedge sys_clk_i) fault <= 1'b0;
	endtask
	task wait_run(input integer n);
		integer i;
		for (i = 0; i < n; i++) begin
			@(posedge sys_clk_i);
			#1;
			if (run_cmd_o === 1'b1) i = n;
		end
		`CHK(run_cmd_o, 1'b1)
	endtask
	// ****
	// scenarios
	// ****
	task t_regs;
		rd(`MARS_A_CTRL, 32'h0000_0001);
		rd(`MARS_A_MAX, 32'h0000_0003);
		rd(`MARS_A_CLR, 32'h0000_003C);
		rd(`MARS_A_DLY, 32'h0000_001E);
		rd(8'h40, 32'h0000_0000);
		$display("register defaults done");
	endtask
	task t_auto;
		wr(`MARS_A_DLY, 32'h0000_0001);
		wr(`MARS_A_STEP, 32'h0000_0001);
		wr(`MARS_A_STAG, 32'h0000_0002);
		wr(`MARS_A_CLR, 32'h0000_0002);
		key(1'b0);
		`CHK(run_cmd_o, 1'b1)
		trip(12'h001, 2'd0);
		wait_run(700);
		rd(`MARS_A_ATT, 32'h0000_0001);
		trip(12'h002, 2'd0);
		wait_run(1300);
		@(posedge sys_clk_i) power_fail_i <= 1'b1;
		trip(12'h005, 2'd0);
		@(posedge sys_clk_i) power_fail_i <= 1'b0;
		wait_run(3100);
		rd(`MARS_A_ATT, 32'h0000_0003);
		rd(`MARS_A_TOT, 32'h0000_0004);
		repeat (1300) @(posedge sys_clk_i);
		rd(`MARS_A_ATT, 32'h0000_0000);
		trip(12'h001, 2'd0);
		$display("automatic restart done");
	endtask
	task t_lock;
		key(1'b0);
		`CHK(run_cmd_o, 1'b1)
		wr(`MARS_A_MAX, 32'h0000_0000);
		trip(12'h000, 2'd1);
		key(1'b0);
		`CHK(run_cmd_o, 1'b0)
		key(1'b1);
		`CHK(lockout_o, 1'b0)
		wr(`MARS_A_MAX, 32'h0000_0003);
		key(1'b0);
		@(posedge sys_clk_i) ovr_en_i <= 1'b1;
		trip(12'h003, 2'd0);
		@(posedge sys_clk_i) alarm_i <= 1'b1;
		repeat (8) @(posedge sys_clk_i);
		#1;
		`CHK(pending_o, 1'b0)
		@(posedge sys_clk_i) alarm_i <= 1'b0;
		key(1'b0);
		trip(12'h003, 2'd0);
		@(posedge sys_clk_i) telem_stop_i <= 1'b1;
		repeat (8) @(posedge sys_clk_i);
		#1;
		`CHK(pending_o, 1'b0)
		`CHK(remain_min_o, 12'h000)
		@(posedge sys_clk_i) telem_stop_i <= 1'b0;
		ovr_en_i <= 1'b0;
		wr(`MARS_A_CTRL, 32'h0000_0000);
		key(1'b0);
		trip(12'h000, 2'd2);
		wr(`MARS_A_CTRL, 32'h0000_0100);
		rd(`MARS_A_TOT, 32'h0000_0000);
		rd(`MARS_A_DLY, 32'h0000_001E);
		$display("lockout and inhibits done");
	endtask
	// hold setting, overload limit and the switch
	task t_modes;
		wr(`MARS_A_DLY, 32'h0000_0001);
		wr(`MARS_A_CTRL, 32'h0000_0005);
		key(1'b0);
		trip(12'h001, 2'd0);
		key(1'b0);
		`CHK(run_cmd_o, 1'b0)
		`CHK(pending_o, 1'b1)
		wr(`MARS_A_CTRL, 32'h0000_0009);
		key(1'b0);
		`CHK(run_cmd_o, 1'b1)
		@(posedge sys_clk_i) overload_i <= 1'b1;
		trip(12'h001, 2'd0);
		wait_run(700);
		trip(12'h000, 2'd1);
		@(posedge sys_clk_i) overload_i <= 1'b0;
		wr(`MARS_A_CTRL, 32'h0000_0003);
		@(posedge sys_clk_i) begin
			hoa_auto_i <= 1'b0;
			hoa_off_i <= 1'b1;
		end
		repeat (6) @(posedge sys_clk_i);
		#1;
		`CHK(lockout_o, 1'b1)
		@(posedge sys_clk_i) begin
			hoa_off_i <= 1'b0;
			hoa_hand_i <= 1'b1;
		end
		repeat (6) @(posedge sys_clk_i);
		#1;
		`CHK(lockout_o, 1'b0)
		key(1'b0);
		`CHK(run_cmd_o, 1'b1)
		trip(12'h000, 2'd2);
		@(posedge sys_clk_i) begin
			hoa_hand_i <= 1'b0;
			hoa_auto_i <= 1'b1;
		end
		$display("modes and switch done");
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// whole run is near 7100 clocks; cut a hang well past that
	initial begin
		repeat (40000) @(posedge sys_clk_i);
		error_cnt++;
		wrap_up;
	end
	initial begin
		repeat (6) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		t_regs;
		t_auto;
		t_lock;
		t_modes;
		wrap_up;
	end
endmodule // tb_motor_auto_restart_sequencer
